// ### design/velocity_profile_generator.sv
// velocity profile generator: target register, ramp counter, comparator, done flags
// assumes host strobes are one-cycle pulses synchronous to sys_clk
`timescale 1ns/1ps
`include "velocity_profile_defs.svh"
module velocity_profile_generator
   import velocity_profile_pkg::*;
#(
   parameter int WIDTH = `VPG_COUNT_WIDTH
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // host target load
   input  wire logic             target_load,
   input  wire logic [WIDTH-1:0] target_data,
   // host commands
   input  wire logic             accel_cmd,
   input  wire logic             decel_cmd,
   input  wire logic             clear_cmd,
   // conversion clock tick
   input  wire logic             conv_tick,
   // converter code
   output logic [WIDTH-1:0]      dac_code,
   // status
   output logic [WIDTH-1:0]      target_value,
   output logic                  counting,
   output logic                  accel_done_irq,
   output logic                  decel_first_done_irq,
   output logic                  decel_final_done_irq
);
   phase_t           phase_q;
   phase_t           phase_d;
   logic [WIDTH-1:0] target_q;
   logic [WIDTH-1:0] target_d;
   logic             irq1_q;
   logic             irq1_d;
   logic             irq2_q;
   logic             irq2_d;
   logic             irq3_q;
   logic             irq3_d;
   logic             up_mode_q;
   logic             up_mode_d;
   logic             run;
   logic             match;
   logic             zero_load;
   logic [WIDTH-1:0] count;

   if (WIDTH != 8) begin : g_width_check
      $error("comparator and converter are eight bits wide");
   end

   assign run       = (phase_q != ph_idle);
   assign match     = run && (count == target_q);
   assign zero_load = accel_cmd;

   ramp_counter #(
      .WIDTH (WIDTH)
   ) u_counter (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .zero_load (zero_load),
      .run       (run && !match),
      .count_up  (up_mode_q),
      .tick      (conv_tick),
      .count     (count)
   );

   // phase sequencing; a second decelerate after stage one enters stage two
   always_comb begin
      phase_d   = phase_q;
      up_mode_d = up_mode_q;
      if (accel_cmd) begin
         phase_d   = ph_accel;
         up_mode_d = 1'b1;
      end else if (decel_cmd) begin
         phase_d   = irq2_q ? decel_stage_two : ph_decel_one;
         up_mode_d = 1'b0;
      end else if (match) begin
         phase_d = ph_idle;
      end
   end

   // target register; automatic clear on first deceleration match
   always_comb begin
      target_d = target_q;
      if (match && phase_q == ph_decel_one) begin
         target_d = '0;
      end else if (target_load) begin
         target_d = target_data;
      end
   end

   // sticky done flags; the set wins over a clear in the same cycle
   always_comb begin
      irq1_d = clear_cmd ? 1'b0 : irq1_q;
      irq2_d = clear_cmd ? 1'b0 : irq2_q;
      irq3_d = clear_cmd ? 1'b0 : irq3_q;
      case (phase_q)
         ph_accel:        if (match) irq1_d = 1'b1;
         ph_decel_one:    if (match) irq2_d = 1'b1;
         decel_stage_two: if (match) irq3_d = 1'b1;
         default:         ;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_q   <= ph_idle;
         up_mode_q <= 1'b0;
         target_q  <= `VPG_TARGET_RESET;
         irq1_q    <= 1'b0;
         irq2_q    <= 1'b0;
         irq3_q    <= 1'b0;
      end else begin
         phase_q   <= phase_d;
         up_mode_q <= up_mode_d;
         target_q  <= target_d;
         irq1_q    <= irq1_d;
         irq2_q    <= irq2_d;
         irq3_q    <= irq3_d;
      end
   end

   assign dac_code             = count;
   assign target_value         = target_q;
   assign counting             = run;
   assign accel_done_irq       = irq1_q;
   assign decel_first_done_irq = irq2_q;
   assign decel_final_done_irq = irq3_q;

   // assertions
   // a match with no command beside it is the end of a phase
   sequence s_accel_match;
      phase_q == ph_accel && match && !accel_cmd && !decel_cmd;
   endsequence
   sequence s_first_match;
      phase_q == ph_decel_one && match && !accel_cmd && !decel_cmd;
   endsequence
   sequence s_final_match;
      phase_q == decel_stage_two && match && !accel_cmd && !decel_cmd;
   endsequence
   // a decelerate picks its stage from the first-decel flag
   sequence s_decel_first_req;
      decel_cmd && !accel_cmd && !decel_first_done_irq;
   endsequence
   sequence s_decel_second_req;
      decel_cmd && !accel_cmd && decel_first_done_irq;
   endsequence

   // ramp start and stepping
   a_accel_start_zero: assert property (@(posedge sys_clk) disable iff (rst)
      accel_cmd |=> dac_code == 8'h00)
      else $error("acceleration did not start from zero");
   a_accel_counts_up: assert property (@(posedge sys_clk) disable iff (rst)
      (phase_q == ph_accel && !match && conv_tick && !accel_cmd && !decel_cmd)
      |=> dac_code == $past(dac_code) + 8'h01)
      else $error("acceleration did not step up");
   a_decel_counts_down: assert property (@(posedge sys_clk) disable iff (rst)
      (phase_q == ph_decel_one && !match && conv_tick && !accel_cmd && !decel_cmd)
      |=> dac_code == $past(dac_code) - 8'h01)
      else $error("deceleration did not step down");
   a_stage_two_down: assert property (@(posedge sys_clk) disable iff (rst)
      (phase_q == decel_stage_two && !match && conv_tick && !accel_cmd && !decel_cmd)
      |=> dac_code == $past(dac_code) - 8'h01)
      else $error("stage two did not step down");
   a_first_stage_pick: assert property (@(posedge sys_clk) disable iff (rst)
      s_decel_first_req |=> phase_q == ph_decel_one && counting)
      else $error("decelerate did not enter stage one");
   a_second_stage_pick: assert property (@(posedge sys_clk) disable iff (rst)
      s_decel_second_req |=> phase_q == decel_stage_two && counting)
      else $error("decelerate did not enter stage two");

   // phase ends
   a_accel_done_set: assert property (@(posedge sys_clk) disable iff (rst)
      s_accel_match |=> accel_done_irq && !counting)
      else $error("accel match did not flag and stop");
   a_first_done_set: assert property (@(posedge sys_clk) disable iff (rst)
      s_first_match |=> decel_first_done_irq && !counting)
      else $error("first decel match did not flag");
   a_target_cleared: assert property (@(posedge sys_clk) disable iff (rst)
      (phase_q == ph_decel_one && match) |=> target_value == 8'h00)
      else $error("target not cleared after first decel");
   a_final_done_set: assert property (@(posedge sys_clk) disable iff (rst)
      s_final_match |=> decel_final_done_irq && !counting)
      else $error("final decel match did not flag");
   a_match_freezes: assert property (@(posedge sys_clk) disable iff (rst)
      (counting && match && !accel_cmd) |=> $stable(dac_code))
      else $error("counter moved on a match");

   // flag lifetime; only clear or reset may drop a flag
   a_clear_flags: assert property (@(posedge sys_clk) disable iff (rst)
      (clear_cmd && !match) |=> !accel_done_irq && !decel_first_done_irq
      && !decel_final_done_irq)
      else $error("clear did not reset flags");
   a_accel_flag_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (accel_done_irq && !clear_cmd) |=> accel_done_irq)
      else $error("accel done flag dropped without clear");
   a_first_flag_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (decel_first_done_irq && !clear_cmd) |=> decel_first_done_irq)
      else $error("first decel flag dropped without clear");
   a_final_flag_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (decel_final_done_irq && !clear_cmd) |=> decel_final_done_irq)
      else $error("final decel flag dropped without clear");
   a_idle_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (!counting && !accel_cmd && !decel_cmd)[*2] |-> $stable(dac_code))
      else $error("stopped counter moved");
endmodule

// ### design/velocity_profile_defs.svh
// constants for the velocity profile generator
// assumes inclusion by the package and by the generator module
`ifndef VELOCITY_PROFILE_DEFS_SVH
`define VELOCITY_PROFILE_DEFS_SVH
`define VPG_COUNT_WIDTH   8
`define VPG_COUNT_RESET   8'h00
`define VPG_TARGET_RESET  8'h00
`endif

// ### design/velocity_profile_pkg.sv
// types shared by the velocity profile generator
// assumes the defs header is on the include path
`include "velocity_profile_defs.svh"
package velocity_profile_pkg;
   typedef enum logic [1:0] {
      ph_idle,
      ph_accel,
      ph_decel_one,
      decel_stage_two
   } phase_t;
endpackage

// ### design/ramp_counter.sv
// up/down ramp counter that steps once per conversion tick
// assumes tick is a one-cycle pulse synchronous to sys_clk
`timescale 1ns/1ps
module ramp_counter
   import velocity_profile_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // control
   input  wire logic             zero_load,
   input  wire logic             run,
   input  wire logic             count_up,
   input  wire logic             tick,
   // value
   output logic [WIDTH-1:0]      count
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   if (WIDTH < 1) begin : g_width_check
      $error("ramp_counter width must be positive");
   end

   always_comb begin
      count_d = count_q;
      if (zero_load) begin
         count_d = '0;
      end else if (run && tick) begin
         count_d = count_up ? count_q + 1'b1 : count_q - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign count = count_q;
endmodule

// ### tb/host_model.sv
// host model: loads the target and sends phase commands as one-cycle pulses
// assumes one bench process calls its tasks
`timescale 1ns/1ps
module host_model (
   // clock
   input  wire logic       sys_clk,
   // commands to the generator
   output logic            target_load,
   output logic [7:0]      target_data,
   output logic            accel_cmd,
   output logic            decel_cmd,
   output logic            clear_cmd
);
   // host-side encoder tally; the generator never sees it
   int                     pulse_cnt;
   initial begin
      {target_load, accel_cmd, decel_cmd, clear_cmd} = 4'h0;
      target_data = 8'h00;
      pulse_cnt = 0;
   end
   // target written before each accelerate and first decelerate phase
   task automatic load(input logic [7:0] v);
      @(posedge sys_clk) {target_load, target_data} <= {1'b1, v};
      // released data shows the inverse, so stale data never looks live
      @(posedge sys_clk) {target_load, target_data} <= {1'b0, ~v};
      #1;
   endtask
   // 0 accelerate, 1 decelerate, 2 clear
   task automatic cmd(input int sel);
      @(posedge sys_clk) {accel_cmd, decel_cmd, clear_cmd} <= 3'h4 >> sel;
      @(posedge sys_clk) {accel_cmd, decel_cmd, clear_cmd} <= 3'h0;
      #1;
   endtask
   // one pulse a clock stands in for paper travel
   task automatic decel_at(input int limit);
      pulse_cnt = 0;
      while (pulse_cnt < limit) begin
         @(posedge sys_clk);
         pulse_cnt++;
      end
      cmd(1);
   endtask
   // cut only on the final flag with the tally on its limit
   function automatic logic cut_ok(input logic final_done, input int limit);
      return final_done && (pulse_cnt == limit);
   endfunction
endmodule

// ### tb/velocity_profile_generator_tb_top.sv
// bench for the velocity profile generator: full profile, short phases and a mid-ramp reset
// assumes host_model drives the command pins
`timescale 1ns/1ps
module velocity_profile_generator_tb_top;
   logic       sys_clk, rst, conv_tick;
   logic       target_load, accel_cmd, decel_cmd, clear_cmd, counting;
   logic       accel_done_irq, decel_first_done_irq, decel_final_done_irq;
   logic [7:0] target_data, dac_code, target_value;
   int         num_errors = 0;
   int         n_tests = 0;
   int         cycles = 0;
   initial sys_clk = 1'b0;
   always #25 sys_clk = ~sys_clk;
   host_model host_u (.sys_clk(sys_clk), .target_load(target_load), .target_data(target_data),
      .accel_cmd(accel_cmd), .decel_cmd(decel_cmd), .clear_cmd(clear_cmd));
   velocity_profile_generator dut_u (.sys_clk(sys_clk), .rst(rst), .target_load(target_load),
      .target_data(target_data), .accel_cmd(accel_cmd), .decel_cmd(decel_cmd),
      .clear_cmd(clear_cmd), .conv_tick(conv_tick), .dac_code(dac_code),
      .target_value(target_value), .counting(counting), .accel_done_irq(accel_done_irq),
      .decel_first_done_irq(decel_first_done_irq), .decel_final_done_irq(decel_final_done_irq));
   task automatic cmp_code(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   // n back-to-back conversion ticks
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk) conv_tick <= 1'b1;
      @(posedge sys_clk) conv_tick <= 1'b0;
      #1;
   endtask
   task automatic full_profile;
      host_u.load(8'h03);
      cmp_code("target_value", 8'h03, target_value);
      host_u.cmd(0);
      cmp_bit("counting", 1'b1, counting);
      cmp_code("dac_code", 8'h00, dac_code);
      ticks(8);
      cmp_code("dac_code", 8'h03, dac_code);
      cmp_bit("accel_done_irq", 1'b1, accel_done_irq);
      cmp_bit("counting", 1'b0, counting);
      host_u.load(8'h01);
      cmp_code("target_value", 8'h01, target_value);
      host_u.decel_at(3);
      cmp_bit("counting", 1'b1, counting);
      cmp_code("dac_code", 8'h03, dac_code);
      ticks(8);
      cmp_code("dac_code", 8'h01, dac_code);
      cmp_bit("decel_first_done_irq", 1'b1, decel_first_done_irq);
      cmp_code("target_value", 8'h00, target_value);
      host_u.decel_at(4);
      cmp_bit("counting", 1'b1, counting);
      ticks(8);
      cmp_code("dac_code", 8'h00, dac_code);
      cmp_bit("decel_final_done_irq", 1'b1, decel_final_done_irq);
      cmp_bit("cut", 1'b1, host_u.cut_ok(decel_final_done_irq, 4));
      cmp_bit("accel_done_irq", 1'b1, accel_done_irq);
      host_u.cmd(2);
      cmp_code("flags", 8'h00, {5'h00, accel_done_irq, decel_first_done_irq, decel_final_done_irq});
      $display("full_profile done");
   endtask
   task automatic short_phases;
      host_u.load(8'h05);
      host_u.cmd(0);
      ticks(2);
      cmp_code("dac_code", 8'h02, dac_code);
      cmp_bit("counting", 1'b1, counting);
      ticks(8);
      cmp_code("dac_code", 8'h05, dac_code);
      host_u.cmd(2);
      host_u.load(8'h00);
      host_u.cmd(0);
      ticks(3);
      cmp_code("dac_code", 8'h00, dac_code);
      cmp_bit("accel_done_irq", 1'b1, accel_done_irq);
      $display("short_phases done");
   endtask
   // reset in mid-ramp, then a target load and an accelerate once reset is released
   task automatic mid_reset;
      host_u.load(8'h10);
      host_u.cmd(0);
      ticks(2);
      cmp_code("dac_code", 8'h02, dac_code);
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      cmp_code("dac_code", 8'h00, dac_code);
      cmp_code("target_value", 8'h00, target_value);
      cmp_bit("counting", 1'b0, counting);
      cmp_code("flags", 8'h00, {5'h00, accel_done_irq, decel_first_done_irq, decel_final_done_irq});
      cmp_bit("cut", 1'b0, host_u.cut_ok(decel_final_done_irq, 4));
      host_u.load(8'h01);
      host_u.cmd(0);
      ticks(3);
      cmp_code("dac_code", 8'h01, dac_code);
      cmp_bit("accel_done_irq", 1'b1, accel_done_irq);
      $display("mid_reset done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // all three scenarios need well under a few hundred cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      conv_tick = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      cmp_code("dac_code", 8'h00, dac_code);
      full_profile();
      short_phases();
      mid_reset();
      conclude();
   end
endmodule
